// >>> hdl/jof_map.vh
// Register map, field positions, reset values and timing constants
// How it works
// - Invalid-data clock bit set: pixel clock runs while frame high, line low.
// - That bit clear: pixel clock edges only while valid bytes are driven, or outside the frame when the free-run bit is set.
// - Marker insertion wraps each compressed non-spoof frame in SOI and EOI markers.
// - Placement bit puts markers inside (1) or outside (0) the frame window.
// - Ignore-height with spoof ends the frame when the data runs out.
// - In that mode each line is padded with dummy bytes to spoof width.
// - Adaptive clocking steps slow to mid at 50%, to fast at 75% fullness.
// - Adaptive clocking steps fast to mid below 50%, to slow below 25%.
// - Every frame starts on the slow output clock source.
// - Byte swap exchanges even and odd bytes of compressed spoof output.
// - Duplication drives line qualifier with the frame qualifier waveform.
// - Status insertion appends status bits 7:0 after last compressed byte.
// - Timing codes add frame start and end codes to uncompressed spoof.
// - Timing codes add start and end of line codes around every line.
// - Freeze bit blocks shadow copies of the output configuration registers.
// - Without freeze, shadows load when input vertical blanking ends.
// - Slow source divides master clock by bits 3:0, reset 1, zero as one.
// - Spoof framing sends FIFO data as frames of spoof width and height.
// - Mid source divides master clock by bits 11:8, zero acts as one.
// - Fast source divides master clock by third reg bits 3:0, zero as one.
`ifndef JOF_MAP_VH
`define JOF_MAP_VH

`define JOF_OFS_BYPASS   8'h0A
`define JOF_OFS_CFG      8'h0D
`define JOF_OFS_DIV12    8'h0E
`define JOF_OFS_DIV3     8'h0F
`define JOF_OFS_WIDTH    8'h10
`define JOF_OFS_HEIGHT   8'h11

`define JOF_RST_BYPASS   1'b1
`define JOF_RST_CFG      12'h007
`define JOF_RST_DIV12    16'h0501
`define JOF_RST_DIV3     8'h03
`define JOF_RST_WIDTH    12'h640
`define JOF_RST_HEIGHT   12'h004

`define JOF_BIT_SPOOF    0
`define JOF_BIT_CLKFREE  1
`define JOF_BIT_INVCLK   2
`define JOF_BIT_MRKINS   3
`define JOF_BIT_MRKIN    4
`define JOF_BIT_IGNH     5
`define JOF_BIT_ADAPT    6
`define JOF_BIT_SWAP     7
`define JOF_BIT_DUP      8
`define JOF_BIT_STAT     9
`define JOF_BIT_CODES    10
`define JOF_BIT_FREEZE   11

`define JOF_DIV1_LSB     0
`define JOF_DIV2_LSB     8
`define JOF_DIV3_LSB     0

`define JOF_SOI          16'hFFD8
`define JOF_EOI          16'hFFD9
`define JOF_SOF          32'hFF00_00AB
`define JOF_EOF          32'hFF00_00B6
`define JOF_SOL          32'hFF00_0080
`define JOF_EOL          32'hFF00_009D
`define JOF_PAD          8'h00

`define JOF_LINE_GAP     4'h4

`endif

// >>> hdl/jof_fifo.v
// Output data FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module jof_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             in_valid,
    input  wire [WIDTH-1:0] in_data,
    output wire             in_ready,
    output wire             out_valid,
    output wire [WIDTH-1:0] out_data,
    input  wire             out_ready,
    output wire [AW:0]      count
);
    localparam [31:0]   DEPTH_W  = DEPTH;
    localparam [31:0]   LAST_W   = DEPTH - 1;
    localparam [AW:0]   FULL_CNT = DEPTH_W[AW:0];
    localparam [AW-1:0] LAST_PTR = LAST_W[AW-1:0];

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      cnt_reg;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = (cnt_reg != FULL_CNT);
    assign out_valid = (cnt_reg != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_reg];
    assign count     = cnt_reg;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            cnt_reg    <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? {AW{1'b0}}
                                                       : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? {AW{1'b0}}
                                                       : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> hdl/jof_clkdiv.v
// Gated pixel clock divider with boundary-only divisor change
`timescale 1ns/1ps
`default_nettype none
module jof_clkdiv (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [3:0] div,
    input  wire       run,
    output wire       pclk,
    output wire       tick,
    output wire       bound
);
    reg       active_reg;
    reg       pclk_reg;
    reg [3:0] cnt_reg;
    reg [3:0] div_reg;

    function [3:0] eff_div;
        input [3:0] d;
        begin
            eff_div = (d == 4'h0) ? 4'h1 : d;
        end
    endfunction

    // Boundary: idle, or the high half just finished
    wire boundary = !active_reg || (pclk_reg && cnt_reg == 4'h0);

    assign tick  = boundary && run;
    assign bound = boundary;
    assign pclk = pclk_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_reg <= 1'b0;
            pclk_reg   <= 1'b0;
            cnt_reg    <= 4'h0;
            div_reg    <= 4'h1;
        end else if (boundary) begin
            pclk_reg <= 1'b0;
            if (run) begin
                active_reg <= 1'b1;
                div_reg    <= eff_div(div);
                cnt_reg    <= eff_div(div) - 4'h1;
            end else begin
                active_reg <= 1'b0;
            end
        end else if (cnt_reg == 4'h0) begin
            pclk_reg <= 1'b1;
            cnt_reg  <= div_reg - 4'h1;
        end else begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/jof_top.v
// Output formatter: framing, markers, codes, adaptive gated pixel clock
`timescale 1ns/1ps
`include "jof_map.vh"
`default_nettype none
module jof_top #(
    parameter FIFO_DEPTH = 4,
    parameter FIFO_AW    = 2
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        reg_wr_en,
    input  wire [7:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    output wire [15:0] reg_rdata,
    input  wire        vblank_end,
    input  wire [7:0]  jpeg_status,
    input  wire        in_valid,
    input  wire [7:0]  in_data,
    input  wire        in_last,
    output wire        in_ready,
    output wire [7:0]  pix_data,
    output wire        frame_window_level,
    output wire        line_valid,
    output wire        pixel_out_clock
);
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_PRE  = 3'd1;
    localparam [2:0] S_HEAD = 3'd2;
    localparam [2:0] S_LINE = 3'd3;
    localparam [2:0] S_GAP  = 3'd4;
    localparam [2:0] S_TAIL = 3'd5;
    localparam [2:0] S_POST = 3'd6;

    // Live configuration and shadow copies
    reg         byp_reg,   byp_sh_reg;
    reg  [11:0] cfg_reg,   cfg_sh_reg;
    reg  [15:0] div12_reg, div12_sh_reg;
    reg  [7:0]  div3_reg,  div3_sh_reg;
    reg  [11:0] wid_reg,   wid_sh_reg;
    reg  [11:0] hgt_reg,   hgt_sh_reg;
    reg  [15:0] rdata_reg;

    reg  [2:0]  state_reg;
    reg  [31:0] q_reg;
    reg  [2:0]  q_cnt_reg;
    reg  [7:0]  pix_reg;
    reg  [11:0] byte_cnt_reg;
    reg  [11:0] line_cnt_reg;
    reg  [3:0]  gap_cnt_reg;
    reg         eol_reg;
    reg         done_reg;
    reg         stat_sent_reg;
    reg  [7:0]  hold_reg;
    reg         hold_vld_reg;
    reg         hold_last_reg;
    reg         odd_reg;
    reg  [1:0]  sel_reg;

    wire        f_valid;
    wire [8:0]  f_out;
    wire        f_ready;
    wire [FIFO_AW:0] f_count;
    wire        tick;
    wire        pclk_bound;
    wire        run;

    wire spoof     = cfg_sh_reg[`JOF_BIT_SPOOF];
    wire uncomp    = byp_sh_reg;
    wire mrk_on    = cfg_sh_reg[`JOF_BIT_MRKINS] && !uncomp && !spoof;
    wire mrk_in    = mrk_on && cfg_sh_reg[`JOF_BIT_MRKIN];
    wire mrk_out   = mrk_on && !cfg_sh_reg[`JOF_BIT_MRKIN];
    wire codes_on  = cfg_sh_reg[`JOF_BIT_CODES] && spoof && uncomp;
    wire swap_on   = cfg_sh_reg[`JOF_BIT_SWAP] && spoof && !uncomp;
    wire stat_need = cfg_sh_reg[`JOF_BIT_STAT] && !uncomp;
    wire f_last    = f_out[8];
    wire q_busy    = (q_cnt_reg != 3'd0);
    wire gap_end   = (gap_cnt_reg == `JOF_LINE_GAP - 4'h1);

    function fill_at;
        input [FIFO_AW:0] c;
        input [2:0]       quarters;
        integer ci;
        begin
            ci = c;
            fill_at = (ci * 4) >= (FIFO_DEPTH * quarters);
        end
    endfunction

    // Data byte source for the line phase
    reg       src_avail;
    reg [7:0] src_byte;
    reg       src_pop;
    reg       src_hold;
    reg       src_stat;
    always @* begin
        src_avail = 1'b0;
        src_byte  = `JOF_PAD;
        src_pop   = 1'b0;
        src_hold  = 1'b0;
        src_stat  = 1'b0;
        if (swap_on && hold_vld_reg && (odd_reg || hold_last_reg)) begin
            src_avail = 1'b1;
            src_byte  = hold_reg;
            src_hold  = 1'b1;
        end else if (swap_on && hold_vld_reg && f_valid) begin
            src_avail = 1'b1;
            src_byte  = f_out[7:0];
            src_pop   = 1'b1;
        end else if (!swap_on && f_valid && !done_reg) begin
            src_avail = 1'b1;
            src_byte  = f_out[7:0];
            src_pop   = 1'b1;
        end else if (done_reg && !hold_vld_reg && stat_need
                     && !stat_sent_reg) begin
            src_avail = 1'b1;
            src_byte  = jpeg_status;
            src_stat  = 1'b1;
        end else if (spoof && done_reg && !hold_vld_reg) begin
            src_avail = 1'b1;
        end
    end

    wire stream_end = done_reg && !hold_vld_reg
                      && (!stat_need || stat_sent_reg);
    wire data_phase = !eol_reg && (!spoof || byte_cnt_reg < wid_sh_reg);
    wire emit_src   = tick && state_reg == S_LINE && !q_busy && data_phase
                      && src_avail;
    wire preload    = swap_on && state_reg == S_LINE && !hold_vld_reg
                      && !odd_reg && f_valid && !done_reg;
    wire frame_over = cfg_sh_reg[`JOF_BIT_IGNH] ? stream_end
                      : (line_cnt_reg + 12'd1 >= hgt_sh_reg);

    assign f_ready = preload || (emit_src && src_pop);

    wire fv = (state_reg == S_HEAD) || (state_reg == S_LINE)
              || (state_reg == S_GAP) || (state_reg == S_TAIL);
    wire lv = (state_reg == S_LINE);

    reg run_c;
    always @* begin
        case (state_reg)
            S_IDLE:  run_c = cfg_sh_reg[`JOF_BIT_CLKFREE];
            S_PRE,
            S_HEAD,
            S_TAIL:  run_c = q_busy;
            S_POST:  run_c = q_busy || cfg_sh_reg[`JOF_BIT_CLKFREE];
            S_LINE:  run_c = q_busy || (data_phase && src_avail);
            // Free run stops before the gap ends so no period straddles
            S_GAP:   run_c = q_busy || (cfg_sh_reg[`JOF_BIT_INVCLK]
                                        && !gap_end);
            default: run_c = 1'b0;
        endcase
    end
    assign run = run_c;

    reg [3:0] div_sel;
    always @* begin
        case (sel_reg)
            2'd1:    div_sel = div12_sh_reg[`JOF_DIV2_LSB +: 4];
            2'd2:    div_sel = div3_sh_reg[`JOF_DIV3_LSB +: 4];
            default: div_sel = div12_sh_reg[`JOF_DIV1_LSB +: 4];
        endcase
    end

    // Register port and shadow transfer
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            byp_reg      <= `JOF_RST_BYPASS;
            cfg_reg      <= `JOF_RST_CFG;
            div12_reg    <= `JOF_RST_DIV12;
            div3_reg     <= `JOF_RST_DIV3;
            wid_reg      <= `JOF_RST_WIDTH;
            hgt_reg      <= `JOF_RST_HEIGHT;
            byp_sh_reg   <= `JOF_RST_BYPASS;
            cfg_sh_reg   <= `JOF_RST_CFG;
            div12_sh_reg <= `JOF_RST_DIV12;
            div3_sh_reg  <= `JOF_RST_DIV3;
            wid_sh_reg   <= `JOF_RST_WIDTH;
            hgt_sh_reg   <= `JOF_RST_HEIGHT;
            rdata_reg    <= 16'h0000;
        end else begin
            if (reg_wr_en) begin
                case (reg_addr)
                    `JOF_OFS_BYPASS: byp_reg   <= reg_wdata[0];
                    `JOF_OFS_CFG:    cfg_reg   <= reg_wdata[11:0];
                    `JOF_OFS_DIV12:  div12_reg <= reg_wdata;
                    `JOF_OFS_DIV3:   div3_reg  <= reg_wdata[7:0];
                    `JOF_OFS_WIDTH:  wid_reg   <= reg_wdata[11:0];
                    `JOF_OFS_HEIGHT: hgt_reg   <= reg_wdata[11:0];
                    default:         ;
                endcase
            end
            if (vblank_end && !cfg_reg[`JOF_BIT_FREEZE]) begin
                byp_sh_reg   <= byp_reg;
                cfg_sh_reg   <= cfg_reg;
                div12_sh_reg <= div12_reg;
                div3_sh_reg  <= div3_reg;
                wid_sh_reg   <= wid_reg;
                hgt_sh_reg   <= hgt_reg;
            end
            case (reg_addr)
                `JOF_OFS_BYPASS: rdata_reg <= {15'h0000, byp_reg};
                `JOF_OFS_CFG:    rdata_reg <= {4'h0, cfg_reg};
                `JOF_OFS_DIV12:  rdata_reg <= div12_reg;
                `JOF_OFS_DIV3:   rdata_reg <= {8'h00, div3_reg};
                `JOF_OFS_WIDTH:  rdata_reg <= {4'h0, wid_reg};
                `JOF_OFS_HEIGHT: rdata_reg <= {4'h0, hgt_reg};
                default:         rdata_reg <= 16'h0000;
            endcase
        end
    end

    // Frame sequencer
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= S_IDLE;
            q_reg         <= 32'h0000_0000;
            q_cnt_reg     <= 3'd0;
            pix_reg       <= 8'h00;
            byte_cnt_reg  <= 12'h000;
            line_cnt_reg  <= 12'h000;
            gap_cnt_reg   <= 4'h0;
            eol_reg       <= 1'b0;
            done_reg      <= 1'b0;
            stat_sent_reg <= 1'b0;
            hold_reg      <= 8'h00;
            hold_vld_reg  <= 1'b0;
            hold_last_reg <= 1'b0;
            odd_reg       <= 1'b0;
            sel_reg       <= 2'd0;
        end else begin
            // Adaptive source selection with hysteresis
            if (!cfg_sh_reg[`JOF_BIT_ADAPT]) begin
                sel_reg <= 2'd0;
            end else begin
                case (sel_reg)
                    2'd0: if (fill_at(f_count, 3'd2)) sel_reg <= 2'd1;
                    2'd1: begin
                        if (fill_at(f_count, 3'd3)) begin
                            sel_reg <= 2'd2;
                        end else if (!fill_at(f_count, 3'd1)) begin
                            sel_reg <= 2'd0;
                        end
                    end
                    2'd2: if (!fill_at(f_count, 3'd2)) sel_reg <= 2'd1;
                    default: sel_reg <= 2'd0;
                endcase
            end
            if (tick && q_busy) begin
                pix_reg   <= q_reg[31:24];
                q_reg     <= {q_reg[23:0], 8'h00};
                q_cnt_reg <= q_cnt_reg - 3'd1;
            end
            if (preload) begin
                hold_reg      <= f_out[7:0];
                hold_vld_reg  <= 1'b1;
                hold_last_reg <= f_last;
                if (f_last) done_reg <= 1'b1;
            end
            if (emit_src) begin
                pix_reg <= src_byte;
                if (spoof) byte_cnt_reg <= byte_cnt_reg + 12'd1;
                if (src_pop && f_last) done_reg <= 1'b1;
                if (src_pop && swap_on) odd_reg <= 1'b1;
                if (src_hold) begin
                    hold_vld_reg <= 1'b0;
                    odd_reg      <= 1'b0;
                end
                if (src_stat) stat_sent_reg <= 1'b1;
            end
            case (state_reg)
                S_IDLE: begin
                    if (f_valid) begin
                        state_reg     <= S_PRE;
                        sel_reg       <= 2'd0;
                        done_reg      <= 1'b0;
                        stat_sent_reg <= 1'b0;
                        line_cnt_reg  <= 12'h000;
                        byte_cnt_reg  <= 12'h000;
                        eol_reg       <= 1'b0;
                        odd_reg       <= 1'b0;
                        if (mrk_out) begin
                            q_reg     <= {`JOF_SOI, 16'h0000};
                            q_cnt_reg <= 3'd2;
                        end
                    end
                end
                S_PRE: begin
                    if (!q_busy && pclk_bound) begin
                        state_reg <= S_HEAD;
                        if (mrk_in) begin
                            q_reg     <= {`JOF_SOI, 16'h0000};
                            q_cnt_reg <= 3'd2;
                        end else if (codes_on) begin
                            q_reg     <= `JOF_SOF;
                            q_cnt_reg <= 3'd4;
                        end
                    end
                end
                S_HEAD: begin
                    if (!q_busy && pclk_bound) begin
                        state_reg <= S_LINE;
                        if (codes_on) begin
                            q_reg     <= `JOF_SOL;
                            q_cnt_reg <= 3'd4;
                        end
                    end
                end
                S_LINE: begin
                    if (!q_busy && !emit_src && pclk_bound) begin
                        if (eol_reg) begin
                            state_reg   <= S_GAP;
                            gap_cnt_reg <= 4'h0;
                        end else if (!spoof) begin
                            if (stream_end) begin
                                state_reg <= S_TAIL;
                                if (mrk_in) begin
                                    q_reg     <= {`JOF_EOI, 16'h0000};
                                    q_cnt_reg <= 3'd2;
                                end
                            end
                        end else if (!data_phase) begin
                            if (codes_on) begin
                                q_reg     <= `JOF_EOL;
                                q_cnt_reg <= 3'd4;
                                eol_reg   <= 1'b1;
                            end else begin
                                state_reg   <= S_GAP;
                                gap_cnt_reg <= 4'h0;
                            end
                        end
                    end
                end
                S_GAP: begin
                    if (!gap_end) begin
                        gap_cnt_reg <= gap_cnt_reg + 4'h1;
                    end else if (pclk_bound) begin
                        if (frame_over) begin
                            state_reg <= S_TAIL;
                            if (codes_on) begin
                                q_reg     <= `JOF_EOF;
                                q_cnt_reg <= 3'd4;
                            end
                        end else begin
                            state_reg    <= S_LINE;
                            line_cnt_reg <= line_cnt_reg + 12'd1;
                            byte_cnt_reg <= 12'h000;
                            eol_reg      <= 1'b0;
                            if (codes_on) begin
                                q_reg     <= `JOF_SOL;
                                q_cnt_reg <= 3'd4;
                            end
                        end
                    end
                end
                S_TAIL: begin
                    if (!q_busy && pclk_bound) begin
                        state_reg <= S_POST;
                        if (mrk_out) begin
                            q_reg     <= {`JOF_EOI, 16'h0000};
                            q_cnt_reg <= 3'd2;
                        end
                    end
                end
                S_POST: begin
                    if (!q_busy) state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    jof_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (in_valid),
        .in_data   ({in_last, in_data}),
        .in_ready  (in_ready),
        .out_valid (f_valid),
        .out_data  (f_out),
        .out_ready (f_ready),
        .count     (f_count)
    );

    jof_clkdiv u_clkdiv (
        .clk   (clk),
        .rst_n (rst_n),
        .div   (div_sel),
        .run   (run),
        .pclk  (pixel_out_clock),
        .tick  (tick),
        .bound (pclk_bound)
    );

    assign pix_data           = pix_reg;
    assign frame_window_level = fv;
    assign line_valid         = cfg_sh_reg[`JOF_BIT_DUP] ? fv : lv;
    assign reg_rdata          = rdata_reg;
endmodule
`default_nettype wire

// >>> verification/jof_monitor.sv
// Port-level assertions for the output formatter
`timescale 1ns/1ps
`default_nettype none
module jof_monitor (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        reg_wr_en,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_rdata,
    input wire logic        in_valid,
    input wire logic        in_ready,
    input wire logic [7:0]  pix_data,
    input wire logic        frame_window_level,
    input wire logic        line_valid,
    input wire logic        pixel_out_clock
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pix_rise_hold: assert property (
        $rose(pixel_out_clock) |-> $stable(pix_data)) else $error("pix moved");
    a_pix_change_low: assert property (
        $changed(pix_data) |-> !pixel_out_clock) else $error("pix on high");
    a_frame_edge_low: assert property (
        $changed(frame_window_level) |-> !pixel_out_clock)
        else $error("frame edge on high clock");
    a_line_edge_low: assert property (
        $changed(line_valid) |-> !pixel_out_clock)
        else $error("line edge on high clock");
    a_line_in_frame: assert property (
        line_valid |-> frame_window_level) else $error("line outside frame");
    a_unmapped_zero: assert property (
        reg_addr == 8'h20 |=> reg_rdata == 16'h0000) else $error("unmapped");
    a_rdata_steady: assert property (
        !reg_wr_en && $past(!reg_wr_en) && $past(rst_n) && $stable(reg_addr)
        |=> $stable(reg_rdata)) else $error("readback moved");
    a_full_by_write: assert property (
        $fell(in_ready) |-> $past(in_valid)) else $error("full without write");
endmodule
bind jof_top jof_monitor mon_u (.clk(clk), .rst_n(rst_n),
    .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_ready(in_ready), .pix_data(pix_data),
    .frame_window_level(frame_window_level), .line_valid(line_valid),
    .pixel_out_clock(pixel_out_clock));
`default_nettype wire

// >>> verification/jof_host_model.sv
// Host capture side: bytes taken at pixel clock rise
`timescale 1ns/1ps
`default_nettype none
module jof_host_model (
    input wire logic       pixel_out_clock,
    input wire logic [7:0] pix_data,
    input wire logic       frame_window_level,
    input wire logic       line_valid
);
    logic [7:0] got[$];
    // Blank-time bytes can only be markers, idle clock is gated
    always @(posedge pixel_out_clock)
        if (line_valid || !frame_window_level) got.push_back(pix_data);
endmodule
`default_nettype wire

// >>> verification/jof_tb_top.sv
// Bench: register reset values, markers, status byte, freeze
`timescale 1ns/1ps
`include "jof_map.vh"
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin fails++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module jpeg_output_formatter_tb_top;
    logic        clk = 0, rst_n = 0, reg_wr_en = 0, vblank_end = 0;
    logic        in_valid = 0, in_last = 0, in_ready, frame_window_level;
    logic        line_valid, pixel_out_clock;
    logic [7:0]  reg_addr = 0, jpeg_status = 0, in_data = 0, pix_data;
    logic [15:0] reg_wdata = 0, reg_rdata, d;
    logic [7:0]  exp_q[$];
    logic [7:0]  ofs[6] = '{8'h0A, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11};
    logic [15:0] rv[6] = '{16'h0001, 16'h0007, 16'h0501, 16'h0003,
                           16'h0640, 16'h0004};
    int          fails = 0, checked = 0, cyc = 0, seed;
    jof_top dut_u (.clk, .rst_n, .reg_wr_en, .reg_addr, .reg_wdata,
        .reg_rdata, .vblank_end, .jpeg_status, .in_valid, .in_data,
        .in_last, .in_ready, .pix_data, .frame_window_level, .line_valid,
        .pixel_out_clock);
    jof_host_model host_u (.pixel_out_clock, .pix_data,
        .frame_window_level, .line_valid);
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(negedge clk);
        {reg_wr_en, reg_addr, reg_wdata} = {1'b1, a, v};
        @(negedge clk);
        reg_wr_en = 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic cfg(input logic [15:0] v);
        wr(`JOF_OFS_CFG, v);
        vblank_end = 1;
        @(negedge clk);
        vblank_end = 0;
    endtask
    task automatic frame(input bit mk, input bit st);
        int n;
        n = 3 + $urandom % 6;
        // Let a free-running period from the last setup finish
        repeat (4) @(negedge clk);
        host_u.got = {};
        jpeg_status = 8'($urandom);
        exp_q = {};
        if (mk) exp_q = {8'hFF, 8'hD8};
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            {in_valid, in_last, in_data} = {1'b1, i == n - 1, 8'($urandom)};
            exp_q.push_back(in_data);
            while (!in_ready) @(negedge clk);
        end
        @(negedge clk);
        in_valid = 0;
        if (st) exp_q.push_back(jpeg_status);
        if (mk) exp_q = {exp_q, 8'hFF, 8'hD9};
        for (int k = 0; k < 3000 && host_u.got.size() < exp_q.size(); k++)
            @(negedge clk);
        repeat (60) @(negedge clk);
        `CHK("count", exp_q.size(), host_u.got.size())
        foreach (exp_q[i]) `CHK("byte", exp_q[i], host_u.got[i])
    endtask
    initial begin
        seed = $urandom(32'h300a);
        repeat (4) @(negedge clk);
        rst_n = 1;
        foreach (ofs[i]) begin
            rd(ofs[i]);
            `CHK("reset value", rv[i], d)
        end
        rd(8'h20);
        `CHK("unmapped", 16'h0000, d)
        wr(`JOF_OFS_DIV12, 16'($urandom) & 16'h0F0F);
        rd(`JOF_OFS_DIV12);
        `CHK("divisors", reg_wdata, d)
        wr(`JOF_OFS_BYPASS, 16'h0000);
        cfg(16'h0008);
        frame(1, 0);
        cfg(16'h0800);
        frame(1, 0);
        cfg(16'h0000);
        frame(0, 0);
        cfg(16'h0208);
        frame(1, 1);
        report_and_stop();
    end
endmodule
`default_nettype wire
